// ===== common/fpu_pkg.sv
// package for the flash protection unit: register map, resets, types
package fpu_pkg;
	// register word indices inside the slave window (byte offset / 4)
	localparam logic [3:0] FPU_OFS_WG_LOW = 4'h0;
	localparam logic [3:0] FPU_OFS_WG_HIGH = 4'h1;
	localparam logic [3:0] FPU_OFS_ACC_DBG = 4'h2;
	localparam logic [3:0] FPU_OFS_DIS_CHAIN = 4'h3;
	localparam logic [3:0] FPU_OFS_REEN_CHAIN = 4'h4;
	localparam logic [3:0] FPU_OFS_SET_PROT = 4'h5;
	localparam logic [3:0] FPU_OFS_STATUS = 4'h6;
	localparam logic [3:0] FPU_OFS_SHADOW_WG = 4'h7;
	localparam logic [3:0] FPU_OFS_SHADOW_AD = 4'h8;
	// documented flash-space offsets of the non-volatile registers
	localparam logic [23:0] FPU_NV_WG_LOW_ADDR = 24'h0EDFB4;
	localparam logic [23:0] FPU_NV_WG_HIGH_ADDR = 24'h0EDFB6;
	localparam logic [23:0] FPU_NV_ACC_DBG_ADDR = 24'h0EDFB8;
	localparam logic [23:0] FPU_NV_DIS_ADDR = 24'h0EDFBC;
	localparam logic [23:0] FPU_NV_REEN_ADDR = 24'h0EDFBE;
	// delivery values of the non-volatile cells
	localparam logic [15:0] FPU_RST_WG_LOW = 16'hFFFF;
	localparam logic [15:0] FPU_RST_WG_HIGH = 16'hFFFF;
	localparam logic [15:0] FPU_RST_ACC_DBG = 16'hACFF;
	localparam logic [15:0] FPU_RST_DIS = 16'hFFFF;
	localparam logic [15:0] FPU_RST_REEN = 16'hFFFF;
	// field positions
	localparam int FPU_BANK0_SECTORS = 10;
	localparam int FPU_BANK1_SECTORS = 2;
	localparam int FPU_ACC_BIT = 0;
	localparam int FPU_DBG_BIT = 1;
	localparam int FPU_CHAIN_LEN = 16;
	localparam int FPU_STAT_WPF_BIT = 0;
	localparam logic [15:0] FPU_TRAP_NUMBER = 16'h009B;
	localparam logic [15:0] FPU_DUMMY_DATA = 16'hFFFF;
	// set-protection command: target select in bits 18:16 of write data
	localparam logic [2:0] FPU_SEL_WG_LOW = 3'h0;
	localparam logic [2:0] FPU_SEL_WG_HIGH = 3'h1;
	localparam logic [2:0] FPU_SEL_ACC_DBG = 3'h2;
	localparam logic [2:0] FPU_SEL_DIS = 3'h3;
	localparam logic [2:0] FPU_SEL_REEN = 3'h4;

	typedef enum logic [1:0] {
		FPU_SRC_FLASH = 2'h0,
		FPU_SRC_IRAM = 2'h1,
		FPU_SRC_XRAM = 2'h3,
		FPU_SRC_EXT = 2'h2
	} fpu_src_e;

	typedef enum logic [1:0] {
		FPU_ST_LOCKED = 2'h0,
		FPU_ST_LOAD = 2'h1,
		FPU_ST_RUN = 2'h3
	} fpu_state_e;

	// one flash access request from a bus master
	typedef struct packed {
		logic valid;
		logic write;
		logic erase;
		logic peripheral_event_transfer;
		logic regs;
		logic bank;
		logic [3:0] sector;
		fpu_src_e src;
		logic src_bank;
	} fpu_req_s;

	// answer to one flash access
	typedef struct packed {
		logic grant;
		logic dummy;
		logic trap;
		logic wp_error;
	} fpu_ans_s;
endpackage : fpu_pkg

// ===== dv/fpu_bus_master.sv
// bus master model: issues one flash access and takes the answer
`timescale 1ns/100ps
`default_nettype none
module fpu_bus_master
	import fpu_pkg::*;
(
	// clock
	input wire logic ref_clk_i,
	// access path
	output fpu_req_s req_o,
	input wire fpu_ans_s ans_i
);
	initial begin
		req_o = '0;
	end
	// released fields are inverted so a stale request never looks held
	task automatic issue(input fpu_req_s r, output fpu_ans_s a);
		@(posedge ref_clk_i);
		req_o <= r;
		@(posedge ref_clk_i);
		req_o <= {1'b0, ~r[$bits(fpu_req_s)-2:0]};
		@(negedge ref_clk_i);
		a = ans_i;
	endtask : issue
endmodule : fpu_bus_master
`default_nettype wire

// ===== dv/tb_top.sv
// testbench: register path and sector write locks
`timescale 1ns/100ps
`default_nettype none
module tb_top import fpu_pkg::*; ;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic wb_src_flash_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	fpu_req_s req_i;
	fpu_ans_s ans_o;
	logic [31:0] q;
	logic guard_o;
	logic dbg_o;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;

	always #4 ref_clk_i = ~ref_clk_i;

	fpu_flash_protection_unit uut (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_src_flash_i(wb_src_flash_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i),
		.ans_o(ans_o), .guard_active_o(guard_o), .debug_enable_o(dbg_o));
	fpu_bus_master master (.ref_clk_i(ref_clk_i), .req_o(req_i),
		.ans_i(ans_o));

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// a hung handshake ends here rather than stalling the run
	always @(posedge ref_clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wb(input logic we, input logic [3:0] idx,
			input logic [31:0] d, input logic src);
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= d;
		wb_src_flash_i <= src;
		do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic setp(input logic nv, input logic [2:0] sel,
			input logic [15:0] v, input logic src);
		wb(1'b1, FPU_OFS_SET_PROT, {12'h000, nv, sel, v}, src);
	endtask : setp

	// program access to one sector from same-bank flash code
	task automatic hit(input logic b, input logic [3:0] s, input logic lk);
		fpu_req_s r;
		fpu_ans_s a;
		r = '0;
		r.valid = 1'b1;
		r.write = 1'b1;
		r.bank = b;
		r.sector = s;
		r.src = FPU_SRC_FLASH;
		r.src_bank = b;
		master.issue(r, a);
		check("grant", 16'(a.grant), 16'(!lk));
		check("wp_error", 16'(a.wp_error), 16'(lk));
	endtask : hit

	// one bank-0 sector-0 access; e packs {grant, dummy, trap, wp_error}
	task automatic acc(input logic w, input logic p, input fpu_src_e s,
			input logic sb, input logic [3:0] e);
		fpu_req_s r;
		fpu_ans_s a;
		r = '0;
		r.valid = 1'b1;
		r.write = w;
		r.peripheral_event_transfer = p;
		r.src = s;
		r.src_bank = sb;
		master.issue(r, a);
		check("answer", 16'(a), 16'(e));
	endtask : acc

	task automatic t_guard();
		check("guard off", 16'(guard_o), 16'h0000);
		check("debug on", 16'(dbg_o), 16'h0001);
		setp(1'b1, FPU_SEL_ACC_DBG, 16'hFFFC, 1'b1);
		setp(1'b0, FPU_SEL_ACC_DBG, 16'h0000, 1'b1);
		repeat (2) @(posedge ref_clk_i);
		check("guard on", 16'(guard_o), 16'h0001);
		check("debug off", 16'(dbg_o), 16'h0000);
		acc(1'b1, 1'b0, FPU_SRC_IRAM, 1'b0, 4'b0000);
		acc(1'b1, 1'b0, FPU_SRC_EXT, 1'b1, 4'b1000);
		acc(1'b0, 1'b0, FPU_SRC_XRAM, 1'b0, 4'b0110);
		acc(1'b0, 1'b1, FPU_SRC_FLASH, 1'b0, 4'b0000);
		acc(1'b0, 1'b0, FPU_SRC_FLASH, 1'b0, 4'b1000);
		setp(1'b1, FPU_SEL_DIS, 16'hFFFE, 1'b1);
		repeat (2) @(posedge ref_clk_i);
		check("pair off", 16'(guard_o), 16'h0000);
		setp(1'b1, FPU_SEL_DIS, 16'hFFFB, 1'b1);
		wb(1'b0, FPU_OFS_DIS_CHAIN, 32'h0, 1'b1);
		check("dis chain", q[15:0], 16'hFFFE);
		setp(1'b1, FPU_SEL_REEN, 16'hFFFD, 1'b1);
		setp(1'b1, FPU_SEL_REEN, 16'hFFFE, 1'b1);
		wb(1'b0, FPU_OFS_REEN_CHAIN, 32'h0, 1'b1);
		check("reen chain", q[15:0], 16'hFFFE);
		repeat (2) @(posedge ref_clk_i);
		check("guard back", 16'(guard_o), 16'h0001);
		$display("test guard done");
	endtask : t_guard

	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
	endtask : do_reset

	task automatic t_unmapped();
		wb(1'b1, 4'hF, 32'h0000FFFF, 1'b1);
		wb(1'b0, 4'hF, 32'h0, 1'b1);
		check("unmapped", q[15:0], 16'h0000);
		$display("test unmapped done");
	endtask : t_unmapped

	task automatic t_bank0();
		setp(1'b1, FPU_SEL_WG_LOW, 16'h0000, 1'b1);
		setp(1'b0, FPU_SEL_WG_LOW, 16'h0000, 1'b1);
		hit(1'b0, 4'h3, 1'b1);
		hit(1'b0, 4'h9, 1'b1);
		wb(1'b0, FPU_OFS_STATUS, 32'h0, 1'b1);
		check("wpf set", 16'(q[0]), 16'h0001);
		wb(1'b1, FPU_OFS_STATUS, 32'h1, 1'b1);
		wb(1'b0, FPU_OFS_STATUS, 32'h0, 1'b1);
		check("wpf clear", 16'(q[0]), 16'h0000);
		setp(1'b0, FPU_SEL_WG_LOW, 16'hFFFF, 1'b1);
		hit(1'b0, 4'h3, 1'b0);
		wb(1'b0, FPU_OFS_WG_LOW, 32'h0, 1'b1);
		check("nv low", 16'(q[9:0]), 16'h0000);
		wb(1'b0, FPU_OFS_SHADOW_WG, 32'h0, 1'b1);
		check("shadow low", 16'(q[9:0]), 16'h03FF);
		$display("test bank0 done");
	endtask : t_bank0

	task automatic t_bank1();
		setp(1'b1, FPU_SEL_WG_HIGH, 16'h0000, 1'b1);
		setp(1'b0, FPU_SEL_WG_HIGH, 16'h0000, 1'b1);
		hit(1'b1, 4'h1, 1'b1);
		setp(1'b0, FPU_SEL_WG_HIGH, 16'hFFFF, 1'b0);
		hit(1'b1, 4'h0, 1'b1);
		setp(1'b0, FPU_SEL_WG_HIGH, 16'hFFFF, 1'b1);
		hit(1'b1, 4'h1, 1'b0);
		$display("test bank1 done");
	endtask : t_bank1

	task automatic t_reload();
		do_reset();
		hit(1'b0, 4'h0, 1'b1);
		hit(1'b1, 4'h1, 1'b1);
		$display("test reload done");
	endtask : t_reload

	initial begin
		do_reset();
		t_unmapped();
		t_bank0();
		t_bank1();
		t_guard();
		t_reload();
		close_out();
	end
endmodule : tb_top
`default_nettype wire

// ===== src/fpu_flash_protection_unit.sv
// flash protection unit: shadow guards, chain logic, access checks
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module fpu_flash_protection_unit
	import fpu_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_src_flash_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// flash access check
	input wire fpu_req_s req_i,
	output fpu_ans_s ans_o,
	// protection state
	output logic guard_active_o,
	output logic debug_enable_o
);
	// non-volatile cells and volatile shadows
	// fuses power up at their delivery values; reset never touches them
	logic [15:0] nv_reg [5] = '{
		FPU_RST_WG_LOW,
		FPU_RST_WG_HIGH,
		FPU_RST_ACC_DBG,
		FPU_RST_DIS,
		FPU_RST_REEN
	};
	logic [15:0] sh_reg [5];
	fpu_state_e state_reg;
	logic wpf_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	fpu_ans_s ans_reg;
	logic guard_reg;
	logic dbg_reg;

	logic acc_wr;
	logic [3:0] idx;
	logic [15:0] wdat;
	logic [2:0] tsel;
	logic pair_off;
	logic guard_on;
	logic [15:0] nv_next [5];
	logic cmd_nv;
	logic cmd_tmp;
	logic wp_hit;
	logic sec_lock;
	logic foreign;

	function automatic logic [15:0] fpu_chain_ok(input logic [15:0] dis,
		input logic [15:0] ren, input logic [15:0] ad);
		logic [15:0] ok;
		ok = '0;
		for (int i = 0; i < FPU_CHAIN_LEN; i++) begin
			if (i == 0)
				ok[i] = ~ad[FPU_DBG_BIT] & ~ad[FPU_ACC_BIT];
			else
				ok[i] = ~ren[i - 1];
		end
		return ok;
	endfunction : fpu_chain_ok

	// bus decode
	// writes act only on the first cycle, so a held request lands once
	assign acc_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;
	assign idx = wb_adr_i[5:2];
	assign wdat = wb_dat_i[15:0];
	assign tsel = wb_dat_i[18:16];
	assign cmd_nv = acc_wr && idx == FPU_OFS_SET_PROT && wb_dat_i[19]
		&& wb_src_flash_i;
	assign cmd_tmp = acc_wr && idx == FPU_OFS_SET_PROT && !wb_dat_i[19]
		&& wb_src_flash_i;

	// a pair is off while disable x is programmed and reenable x is not
	always_comb begin
		pair_off = 1'b0;
		for (int i = 0; i < FPU_CHAIN_LEN; i++)
			pair_off = pair_off | (~nv_reg[3][i] & nv_reg[4][i]);
	end
	assign guard_on = ~sh_reg[2][FPU_ACC_BIT] & ~pair_off;

	// non-volatile programming: only 1 to 0, chained ordering
	always_comb begin
		logic [15:0] ok;
		ok = '0;
		for (int r = 0; r < 5; r++)
			nv_next[r] = nv_reg[r];
		if (cmd_nv) begin
			case (tsel)
				FPU_SEL_WG_LOW: nv_next[0] = nv_reg[0] & wdat;
				FPU_SEL_WG_HIGH: nv_next[1] = nv_reg[1] & wdat;
				FPU_SEL_ACC_DBG: nv_next[2] = nv_reg[2] & wdat;
				FPU_SEL_DIS: begin
					ok = fpu_chain_ok(nv_reg[3], nv_reg[4], nv_reg[2]);
					nv_next[3] = nv_reg[3] & (wdat | ~ok);
				end
				FPU_SEL_REEN: begin
					nv_next[4] = nv_reg[4] & (wdat | nv_reg[3]);
				end
				default: ;
			endcase
		end
	end

	// non-volatile cells keep their value across reset
	always_ff @(posedge ref_clk_i) begin
		for (int r = 0; r < 5; r++)
			nv_reg[r] <= nv_next[r];
	end

	// reset sequencing: guards forced, then one load
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i)
			state_reg <= FPU_ST_LOCKED;
		else begin
			case (state_reg)
				FPU_ST_LOCKED: state_reg <= FPU_ST_LOAD;
				FPU_ST_LOAD: state_reg <= FPU_ST_RUN;
				FPU_ST_RUN: state_reg <= FPU_ST_RUN;
				default: state_reg <= FPU_ST_LOCKED;
			endcase
		end
	end

	// shadows: forced active in reset, loaded once, temp unprotect
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			for (int r = 0; r < 5; r++)
				sh_reg[r] <= 16'h0000;
		end else if (state_reg == FPU_ST_LOAD) begin
			for (int r = 0; r < 5; r++)
				sh_reg[r] <= nv_reg[r];
		end else if (cmd_tmp && tsel <= FPU_SEL_ACC_DBG) begin
			// ones unlock, zeros back to the non-volatile value
			sh_reg[tsel] <= (wdat & (sh_reg[tsel] | wdat)) | nv_reg[tsel];
		end
	end

	// access check
	// any fetch source other than the flash counts as foreign code
	assign foreign = req_i.src != FPU_SRC_FLASH;
	always_comb begin
		sec_lock = req_i.bank ? ~sh_reg[1][req_i.sector[0]]
			: (req_i.sector < 4'(FPU_BANK0_SECTORS)
			&& ~sh_reg[0][req_i.sector]);
		wp_hit = req_i.valid & (req_i.write | req_i.erase) & sec_lock;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i)
			ans_reg <= '0;
		else begin
			ans_reg.wp_error <= wp_hit;
			ans_reg.dummy <= 1'b0;
			ans_reg.trap <= 1'b0;
			ans_reg.grant <= 1'b0;
			if (req_i.valid) begin
				if (req_i.regs)
					ans_reg.grant <= ~req_i.write | ~foreign | ~guard_on;
				else if (wp_hit)
					ans_reg.grant <= 1'b0;
				else if (guard_on && req_i.peripheral_event_transfer)
					ans_reg.grant <= 1'b0;
				else if (guard_on && req_i.write && foreign
					&& !(req_i.src_bank != req_i.bank))
					ans_reg.grant <= 1'b0;
				else if (guard_on && !req_i.write && !req_i.erase && foreign) begin
					ans_reg.dummy <= 1'b1;
					ans_reg.trap <= 1'b1;
				end else
					ans_reg.grant <= 1'b1;
			end
		end
	end

	// error flag: set wins over software clear
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i)
			wpf_reg <= 1'b0;
		else if (wp_hit)
			wpf_reg <= 1'b1;
		else if (acc_wr && idx == FPU_OFS_STATUS && wb_sel_i[0]
			&& wb_dat_i[FPU_STAT_WPF_BIT])
			wpf_reg <= 1'b0;
	end

	// status outputs
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			guard_reg <= 1'b1;
			dbg_reg <= 1'b0;
		end else begin
			guard_reg <= guard_on | state_reg != FPU_ST_RUN;
			dbg_reg <= sh_reg[2][FPU_DBG_BIT] & state_reg == FPU_ST_RUN;
		end
	end

	// wishbone answer: one cycle after the request, dropped next cycle
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= '0;
		end else begin
			ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
			rdat_reg <= '0;
			if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) begin
				case (idx)
					FPU_OFS_WG_LOW: rdat_reg[15:0] <= nv_reg[0];
					FPU_OFS_WG_HIGH: rdat_reg[15:0] <= nv_reg[1];
					FPU_OFS_ACC_DBG: rdat_reg[15:0] <= nv_reg[2];
					FPU_OFS_DIS_CHAIN: rdat_reg[15:0] <= nv_reg[3];
					FPU_OFS_REEN_CHAIN: rdat_reg[15:0] <= nv_reg[4];
					FPU_OFS_STATUS: rdat_reg[2:0] <= {dbg_reg, guard_reg, wpf_reg};
					FPU_OFS_SHADOW_WG: rdat_reg <= {sh_reg[1], sh_reg[0]};
					FPU_OFS_SHADOW_AD: rdat_reg[15:0] <= sh_reg[2];
					default: rdat_reg <= '0;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign ans_o = ans_reg;
	assign guard_active_o = guard_reg;
	assign debug_enable_o = dbg_reg;

	// reenable bit 0 is programmed only once disable bit 0 is programmed
	chain_order_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(nv_reg[4][0]) |-> !nv_reg[3][0])
		else $error("reenable programmed before disable");
	wpf_set_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		wp_hit |=> wpf_reg && !ans_reg.grant)
		else $error("locked sector hit not flagged");
	trap_dummy_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		ans_reg.trap |-> ans_reg.dummy && !ans_reg.grant)
		else $error("trap without dummy data");
	pec_block_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_i.valid && req_i.peripheral_event_transfer && !req_i.regs && guard_on |=> !ans_reg.grant)
		else $error("event transfer passed guard");
	reset_force_a: assert property (@(posedge ref_clk_i)
		!reset_n_i |=> guard_active_o && !debug_enable_o)
		else $error("guards not forced in reset");
	ack_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	nv_one_way_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(nv_reg[2] & ~$past(nv_reg[2])) == 16'h0000)
		else $error("non-volatile bit rose");
	dis0_order_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(nv_reg[3][0]) |-> !nv_reg[2][FPU_ACC_BIT] && !nv_reg[2][FPU_DBG_BIT])
		else $error("first disable without guards programmed");

	// sector locks refuse program and erase with an error
	bank0_lock_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && !req_i.bank && (req_i.write || req_i.erase)
		&& req_i.sector < 4'(FPU_BANK0_SECTORS)
		&& !sh_reg[0][req_i.sector]
		|=> !ans_reg.grant && ans_reg.wp_error)
		else $error("bank-0 locked sector not refused");
	bank1_lock_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && req_i.bank && (req_i.write || req_i.erase)
		&& !sh_reg[1][req_i.sector[0]]
		|=> !ans_reg.grant && ans_reg.wp_error)
		else $error("bank-1 locked sector not refused");
	sector_free_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && !req_i.bank
		&& req_i.sector >= 4'(FPU_BANK0_SECTORS)
		|=> !ans_reg.wp_error)
		else $error("unlockable sector flagged");

	// access guard decisions
	flash_read_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && !req_i.regs && !req_i.write && !req_i.erase
		&& !req_i.peripheral_event_transfer && !foreign
		|=> ans_reg.grant)
		else $error("flash code read refused");
	foreign_read_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && !req_i.regs && !req_i.write && !req_i.erase
		&& !req_i.peripheral_event_transfer && foreign && guard_on
		|=> ans_reg.trap && ans_reg.dummy)
		else $error("foreign read not trapped");
	foreign_write_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && !req_i.regs && req_i.write && foreign && guard_on
		&& req_i.src_bank == req_i.bank
		|=> !ans_reg.grant)
		else $error("foreign write reached guarded flash");
	other_bank_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && !req_i.regs && req_i.write && !req_i.peripheral_event_transfer
		&& foreign && req_i.src_bank != req_i.bank && !wp_hit
		|=> ans_reg.grant)
		else $error("other-bank update refused");
	reg_write_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		req_i.valid && req_i.regs && req_i.write && foreign && guard_on
		|=> !ans_reg.grant)
		else $error("foreign register write granted");

	// effective guard and debug outputs
	pair_off_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		state_reg == FPU_ST_RUN && pair_off |=> !guard_active_o)
		else $error("disabled pair left guard on");
	guard_on_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		state_reg == FPU_ST_RUN && guard_on |=> guard_active_o)
		else $error("guard not effective");
	debug_follow_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		state_reg == FPU_ST_RUN
		|=> debug_enable_o == $past(sh_reg[2][FPU_DBG_BIT]))
		else $error("debug enable off its guard bit");

	// shadow handling
	load_once_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		state_reg == FPU_ST_LOAD
		|=> sh_reg[0] == $past(nv_reg[0]) && sh_reg[2] == $past(nv_reg[2]))
		else $error("shadows not loaded from cells");
	temp_unlock_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		cmd_tmp && tsel == FPU_SEL_WG_LOW && state_reg == FPU_ST_RUN
		|=> sh_reg[0] == ($past(wdat) | nv_reg[0]))
		else $error("temporary unlock wrong");
	nv_hidden_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		cmd_tmp
		|=> nv_reg[0] == $past(nv_reg[0]) && nv_reg[2] == $past(nv_reg[2]))
		else $error("temporary unlock touched cells");
	foreign_cmd_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		acc_wr && idx == FPU_OFS_SET_PROT && !wb_src_flash_i
		&& state_reg == FPU_ST_RUN
		|=> sh_reg[2] == $past(sh_reg[2]) && nv_reg[2] == $past(nv_reg[2]))
		else $error("foreign set-protection accepted");

	// register bus answers every request once
	ack_answer_a: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request left unanswered");

	// every later link of the chain keeps its order
	for (genvar g = 1; g < FPU_CHAIN_LEN; g++) begin : g_chain
		dis_link_a: assert property (@(posedge ref_clk_i)
			disable iff (!reset_n_i)
			$fell(nv_reg[3][g]) |-> !nv_reg[4][g - 1])
			else $error("disable programmed out of order");
		reen_link_a: assert property (@(posedge ref_clk_i)
			disable iff (!reset_n_i)
			$fell(nv_reg[4][g]) |-> !nv_reg[3][g])
			else $error("reenable programmed out of order");
	end

	// no cell ever goes back from 0 to 1
	for (genvar g = 0; g < 5; g++) begin : g_fuse
		nv_fuse_a: assert property (@(posedge ref_clk_i)
			disable iff (!reset_n_i)
			(nv_reg[g] & ~$past(nv_reg[g])) == 16'h0000)
			else $error("cell bit rose");
	end
endmodule : fpu_flash_protection_unit

`default_nettype wire
